// >>> shared/ocirq_pkg.sv
// constants, field layout and carrier types of the oscillator irq/event unit
// assumes one clock; status inputs may come from other clock domains
package ocirq_pkg;

  // number of interrupt sources
  localparam int unsigned NumSrc = 6;

  // register byte offsets
  localparam logic [7:0] OffEnClr  = 8'h00;
  localparam logic [7:0] OffEnSet  = 8'h04;
  localparam logic [7:0] OffFlag   = 8'h08;
  localparam logic [7:0] OffEvCtrl = 8'h0C;
  localparam logic [7:0] OffStatus = 8'h10;

  // bit positions of the sources
  localparam int unsigned BitClkFail   = 0;
  localparam int unsigned BitOscRdy    = 1;
  localparam int unsigned BitLockRise  = 2;
  localparam int unsigned BitLockFall  = 3;
  localparam int unsigned BitLockTmo   = 4;
  localparam int unsigned BitRatioDone = 5;

  // event control: failure event output enable position
  localparam int unsigned BitFailEvOe = 0;
  // status register: clock switched position
  localparam int unsigned BitClkSw    = 6;

  // reset values
  localparam logic [5:0] RstFlags  = 6'h00;
  localparam logic [5:0] RstEnable = 6'h00;
  localparam logic       RstEvOe   = 1'b0;

  // raw status levels from the oscillator logic
  typedef struct packed {
    logic clockSwitched;
    logic pllRatioUpdateDone;
    logic pllLockTimeout;
    logic pllLockFall;
    logic pllLockRise;
    logic fastOscReady;
    logic clockFailureFlag;
  } ocirq_status_t;

  // wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } ocirq_wb_req_t;

endpackage : ocirq_pkg

// >>> rtl/ocirq_unit.sv
// oscillator control irq and clock-failure event logic, wishbone slave
// assumes status levels are asynchronous and pass two flops here
//
// Our own choices: the placing of the registers and register access over Wishbone.
module ocirq_unit (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  ocirq_pkg::ocirq_wb_req_t    wbReq,
  output logic [31:0]                 wbDatO,
  output logic                        wbAck,
  input  ocirq_pkg::ocirq_status_t    statusIn,
  output logic                        irqOut,
  output logic                        wakeOut,
  output logic                        failEventOut
);
  import ocirq_pkg::*;

  // status synchroniser, two stages
  ocirq_status_t syncA_q;       // first stage, read only by second
  ocirq_status_t syncB_q;       // second stage, safe to use
  ocirq_status_t prev_q;        // last value for edge detect

  // registers
  logic [5:0] flags_q;          // sticky interrupt flags
  logic [5:0] enable_q;         // per-source enables
  logic       evOe_q;           // fail event output enable

  // bus decode
  logic       busReq;           // fresh request not yet acked
  logic       wrStb;            // write strobe this cycle
  logic       lane0;            // low byte selected
  logic [5:0] rise;             // rising edges of sources
  logic [5:0] srcNow;           // current synced source levels
  logic [5:0] srcOld;           // previous synced source levels
  logic       wrFlag;           // write hit on the flag register
  logic       wrSet;            // write hit on enable set
  logic       wrClr;            // write hit on enable clear
  logic       wrEv;             // write hit on event control

  // pack source levels into flag order
  function automatic logic [5:0] srcVec(input ocirq_status_t s);
    srcVec = {s.pllRatioUpdateDone, s.pllLockTimeout, s.pllLockFall,
              s.pllLockRise, s.fastOscReady, s.clockFailureFlag};
  endfunction : srcVec

  // write hit on one register, low byte lane only
  function automatic logic regWrite(input logic       stb,
                                    input logic       lane,
                                    input logic [7:0] adr,
                                    input logic [7:0] off);
    regWrite = stb & lane & (adr == off);
  endfunction : regWrite

  assign busReq = wbReq.cyc & wbReq.stb & ~wbAck;
  assign wrStb  = busReq & wbReq.we;
  assign lane0  = wbReq.sel[0];
  assign srcNow = srcVec(syncB_q);
  assign srcOld = srcVec(prev_q);

  // per-register write strokes, all fields sit in the low byte
  // flag clear stroke
  assign wrFlag = regWrite(wrStb, lane0, wbReq.adr, OffFlag);
  assign wrSet  = regWrite(wrStb, lane0, wbReq.adr, OffEnSet);
  assign wrClr  = regWrite(wrStb, lane0, wbReq.adr, OffEnClr);
  assign wrEv   = regWrite(wrStb, lane0, wbReq.adr, OffEvCtrl);

  // status levels arrive from other clock domains; a level that is
  // already high when reset lifts is seen as a fresh edge about two
  // cycles later, because the history starts from zero. software that
  // cares must clear the flags once after reset.
  // a pulse on a status level shorter than one clock may be missed;
  // the oscillator logic holds its status bits for many cycles, so
  // this is accepted rather than paying for a pulse stretcher.

  assign rise = srcNow & ~srcOld;

  // synchroniser and edge history
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncA_q <= '0;
      syncB_q <= '0;
      prev_q  <= '0;
    end else begin
      syncA_q <= statusIn;
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
    end
  end

  // sticky flags, set wins over write-one clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_q <= RstFlags;
    end else if (wrFlag) begin
      flags_q <= (flags_q & ~wbReq.dat[5:0]) | rise;
    end else begin
      flags_q <= flags_q | rise;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enable_q <= RstEnable;
    end else if (wrSet) begin
      enable_q <= enable_q | wbReq.dat[5:0];
    end else if (wrClr) begin
      enable_q <= enable_q & ~wbReq.dat[5:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evOe_q <= RstEvOe;
    end else if (wrEv) begin
      evOe_q <= wbReq.dat[BitFailEvOe];
    end
  end

  // one shared level request from flags and enables
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(flags_q & enable_q);
    end
  end

  // wake pulse on any enabled source edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wakeOut <= 1'b0;
    end else begin
      wakeOut <= |(rise & enable_q);
    end
  end

  // one-cycle failure event, blocked when switched
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      failEventOut <= 1'b0;
    end else begin
      failEventOut <= rise[BitClkFail] & evOe_q & ~syncB_q.clockSwitched;
    end
  end

  // wishbone ack and read data, one wait state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wbAck  <= 1'b0;
      wbDatO <= 32'h0000_0000;
    end else begin
      wbAck <= busReq;
      if (busReq && !wbReq.we) begin
        if (wbReq.adr == OffFlag) begin
          wbDatO <= {26'h0, flags_q};
        end else if (wbReq.adr == OffEnSet || wbReq.adr == OffEnClr) begin
          wbDatO <= {26'h0, enable_q};
        end else if (wbReq.adr == OffEvCtrl) begin
          wbDatO <= {31'h0, evOe_q};
        end else if (wbReq.adr == OffStatus) begin
          wbDatO <= {25'h0, syncB_q.clockSwitched, srcNow};
        end else begin
          wbDatO <= 32'h0000_0000; // unmapped reads zero
        end
      end else begin
        wbDatO <= 32'h0000_0000;
      end
    end
  end

  // request follows flags and enables one cycle later
  a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 irqOut == $past(|(flags_q & enable_q)))
    else $error("irq does not match flags and enables");

  a_clock_failure_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
    rise[BitClkFail] |=> flags_q[BitClkFail])
    else $error("clock failure flag not set");

  a_oscrdy_set: assert property (@(posedge ref_clk) disable iff (rst)
    rise[BitOscRdy] |=> flags_q[BitOscRdy])
    else $error("osc ready flag not set");

  a_lockrise_set: assert property (@(posedge ref_clk) disable iff (rst)
    rise[BitLockRise] |=> flags_q[BitLockRise])
    else $error("lock rise flag not set");

  a_lockfall_set: assert property (@(posedge ref_clk) disable iff (rst)
    rise[BitLockFall] |=> flags_q[BitLockFall])
    else $error("lock fall flag not set");

  a_locktmo_set: assert property (@(posedge ref_clk) disable iff (rst)
    rise[BitLockTmo] |=> flags_q[BitLockTmo])
    else $error("lock timeout flag not set");

  a_ratio_set: assert property (@(posedge ref_clk) disable iff (rst)
    rise[BitRatioDone] |=> flags_q[BitRatioDone])
    else $error("ratio done flag not set");

  a_enset_write: assert property (@(posedge ref_clk) disable iff (rst)
    wrStb && lane0 && wbReq.adr == OffEnSet && wbReq.dat[0] |=> enable_q[0])
    else $error("enable set failed");

  a_enclr_write: assert property (@(posedge ref_clk) disable iff (rst)
    wrStb && lane0 && wbReq.adr == OffEnClr && wbReq.dat[0] |=> !enable_q[0])
    else $error("enable clear failed");

  // flag 0 stays set without a clearing write
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    flags_q[0] && !(wrStb && wbReq.adr == OffFlag) |=> flags_q[0])
    else $error("flag dropped without clear");

  // event only from edge with enable and no switch
  a_fail_event: assert property (@(posedge ref_clk) disable iff (rst)
    failEventOut |-> $past(rise[BitClkFail] && evOe_q &&
                           !syncB_q.clockSwitched))
    else $error("spurious failure event");

  // write one clears flag unless edge at same time
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (rst)
    wrStb && lane0 && wbReq.adr == OffFlag && wbReq.dat[0] && !rise[0]
    |=> !flags_q[0])
    else $error("flag clear failed");

  // named steps of one bus access
  // request taken on an edge with ack low
  sequence s_bus_take;
    busReq;
  endsequence : s_bus_take

  // ack for exactly one cycle, then low
  sequence s_bus_answer;
    wbAck ##1 !wbAck;
  endsequence : s_bus_answer

  // read of the flag register taken
  sequence s_flag_read;
    busReq && !wbReq.we && wbReq.adr == OffFlag;
  endsequence : s_flag_read

  // read of either enable view taken
  sequence s_enable_read;
    busReq && !wbReq.we &&
    (wbReq.adr == OffEnSet || wbReq.adr == OffEnClr);
  endsequence : s_enable_read

  // bus answers in one cycle
  a_bus_ack: assert property (@(posedge ref_clk) disable iff (rst)
    s_bus_take |=> s_bus_answer)
    else $error("ack timing wrong");

  // flag read returns the flags of the taking edge
  a_flag_read: assert property (@(posedge ref_clk) disable iff (rst)
    s_flag_read |=> wbDatO == {26'h0, $past(flags_q)})
    else $error("flag read data wrong");

  // enable read returns the enables of the taking edge
  a_enable_read: assert property (@(posedge ref_clk) disable iff (rst)
    s_enable_read |=> wbDatO == {26'h0, $past(enable_q)})
    else $error("enable read data wrong");

  a_event_control_reg_read: assert property (@(posedge ref_clk) disable iff (rst)
    busReq && !wbReq.we && wbReq.adr == OffEvCtrl
    |=> wbDatO == {31'h0, $past(evOe_q)})
    else $error("event control read wrong");

  a_status_read: assert property (@(posedge ref_clk) disable iff (rst)
    busReq && !wbReq.we && wbReq.adr == OffStatus
    |=> wbDatO == {25'h0, $past(syncB_q.clockSwitched), $past(srcNow)})
    else $error("status read wrong");

  // read data is zero outside an answer
  a_data_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !wbAck |-> wbDatO == 32'h0000_0000)
    else $error("read data outside answer");

  // a write answers with zero data
  a_write_data: assert property (@(posedge ref_clk) disable iff (rst)
    busReq && wbReq.we |=> wbDatO == 32'h0000_0000)
    else $error("write answer carries data");

  // set write never clears an enable
  a_enset_keep: assert property (@(posedge ref_clk) disable iff (rst)
    wrSet |=> (($past(enable_q) & ~enable_q) == 6'h00))
    else $error("set write cleared an enable");

  // clear write never sets an enable
  a_enclr_keep: assert property (@(posedge ref_clk) disable iff (rst)
    wrClr |=> ((enable_q & ~$past(enable_q)) == 6'h00))
    else $error("clear write set an enable");

  // enables only move on a write to them
  a_enable_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !wrSet && !wrClr |=> enable_q == $past(enable_q))
    else $error("enables moved without write");

  // writes without the low lane leave the event enable unchanged
  a_sel_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    busReq && wbReq.we && !lane0 |=> evOe_q == $past(evOe_q))
    else $error("write without lane took effect");

  // flags only rise from a source edge
  a_flag_origin: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> ((flags_q & ~$past(flags_q) & ~$past(rise)) == 6'h00))
    else $error("flag set without edge");

  // set wins over a clear in the same cycle
  a_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    wrFlag && rise[0] |=> flags_q[0])
    else $error("clear beat a set");

  // enabled edge gives a wake pulse
  a_wake_fire: assert property (@(posedge ref_clk) disable iff (rst)
    |(rise & enable_q) |=> wakeOut)
    else $error("wake pulse missing");

  // no wake pulse without an enabled edge
  a_wake_origin: assert property (@(posedge ref_clk) disable iff (rst)
    wakeOut |-> $past(|(rise & enable_q)))
    else $error("spurious wake pulse");

  // unblocked failure edge emits the event
  a_event_fire: assert property (@(posedge ref_clk) disable iff (rst)
    rise[BitClkFail] && evOe_q && !syncB_q.clockSwitched
    |=> failEventOut)
    else $error("failure event missing");

  a_event_block: assert property (@(posedge ref_clk) disable iff (rst)
    syncB_q.clockSwitched |=> !failEventOut)
    else $error("event while switched");

  // event enable follows the written bit
  a_evoe_write: assert property (@(posedge ref_clk) disable iff (rst)
    wrEv |=> evOe_q == $past(wbReq.dat[BitFailEvOe]))
    else $error("event enable write lost");

  // request stays while a flag and its enable stay
  a_irq_hold: assert property (@(posedge ref_clk) disable iff (rst)
    irqOut && (flags_q & enable_q) != 6'h00 |=> irqOut)
    else $error("request dropped early");

  // request drops once nothing is pending
  a_irq_fall: assert property (@(posedge ref_clk) disable iff (rst)
    (flags_q & enable_q) == 6'h00 |=> !irqOut)
    else $error("request without pending flag");

  // synchroniser second stage copies the first
  a_sync_pipe: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> syncB_q == $past(syncA_q))
    else $error("synchroniser stage skipped");

endmodule : ocirq_unit

// >>> verif/ocirq_sink.sv
// far side model: interrupt controller and event router counters
// assumes one clock and registered outputs from the unit
module ocirq_sink (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic globalEn,
  input  wire logic irqOut,
  input  wire logic wakeOut,
  input  wire logic failEventOut,
  output int        evCount,
  output int        wakeCount,
  output int        irqTaken
);
  // counts of received pulses and accepted requests
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      evCount   <= 0;
      wakeCount <= 0;
      irqTaken  <= 0;
    end else begin
      evCount   <= evCount + int'(failEventOut);
      wakeCount <= wakeCount + int'(wakeOut);
      irqTaken  <= irqTaken + int'(irqOut && globalEn);
    end
  end
endmodule : ocirq_sink

// >>> verif/ocirq_unit_tb_top.sv
// directed bench for the oscillator irq and event unit
// assumes wishbone answer one cycle after request, no parameters
module ocirq_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ocirq_pkg::*;
  logic          ref_clk, rst, wbAck, irqOut, wakeOut, failEventOut;
  logic          globalEn;
  logic [31:0]   wbDatO, rd;
  ocirq_wb_req_t wbReq;
  ocirq_status_t statusIn;
  int            errors, compares, cycles, evCount, wakeCount, irqTaken;

  ocirq_unit u_ocirq_unit (.ref_clk(ref_clk), .rst(rst), .wbReq(wbReq),
    .wbDatO(wbDatO), .wbAck(wbAck), .statusIn(statusIn), .irqOut(irqOut),
    .wakeOut(wakeOut), .failEventOut(failEventOut));
  ocirq_sink u_ocirq_sink (.ref_clk(ref_clk), .rst(rst), .globalEn(globalEn),
    .irqOut(irqOut), .wakeOut(wakeOut), .failEventOut(failEventOut),
    .evCount(evCount), .wakeCount(wakeCount), .irqTaken(irqTaken));

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled high at a rising edge
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    wbReq <= '{1'b1, 1'b1, we, 4'hF, a, d};
    do begin
      @(posedge ref_clk);
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbReq <= '0;
    @(posedge ref_clk);
  endtask : wb

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdc

  task automatic t_reset;
    rdc("enables", OffEnSet, 32'h0);
    rdc("flags", OffFlag, 32'h0);
    rdc("event_control_reg", OffEvCtrl, 32'h0);
    rdc("unmapped", 8'h20, 32'h0);
  endtask : t_reset

  // each source edge sets only its own flag
  task automatic t_edges;
    for (int i = 0; i < 6; i++) begin
      statusIn[i] <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rdc("flag", OffFlag, 32'h1 << i);
      wb(1'b1, OffFlag, 32'h1 << i);
      rdc("flag clr", OffFlag, 32'h0);
      statusIn[i] <= 1'b0;
    end
    chk("wake off", wakeCount, 0);
    chk("ev off", evCount, 0);
    chk("irq off", irqOut, 1'b0);
  endtask : t_edges

  task automatic t_irq;
    globalEn <= 1'b0;
    wb(1'b1, OffEnSet, 32'h4);
    wb(1'b1, OffEnSet, 32'h0);
    rdc("en", OffEnClr, 32'h4);
    statusIn.pllLockRise <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("irq", irqOut, 1'b1);
    chk("wake", wakeCount, 1);
    chk("masked", irqTaken, 0);
    globalEn <= 1'b1;
    wb(1'b1, OffEnClr, 32'h0);
    chk("irq hold", irqOut, 1'b1);
    wb(1'b1, OffEnClr, 32'h4);
    chk("irq dis", irqOut, 1'b0);
    rdc("pending", OffFlag, 32'h4);
    wb(1'b1, OffEnSet, 32'h4);
    chk("taken", irqTaken > 0, 1'b1);
    wb(1'b1, OffFlag, 32'h4);
    chk("irq clr", irqOut, 1'b0);
    statusIn.pllLockRise <= 1'b0;
  endtask : t_irq

  task automatic fail_pulse;
    statusIn.clockFailureFlag <= 1'b1;
    repeat (6) @(posedge ref_clk);
    statusIn.clockFailureFlag <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : fail_pulse

  task automatic t_event;
    wb(1'b1, OffEvCtrl, 32'h1);
    fail_pulse();
    chk("event", evCount, 1);
    statusIn.clockSwitched <= 1'b1;
    fail_pulse();
    chk("ev switched", evCount, 1);
    statusIn.clockSwitched <= 1'b0;
    wb(1'b1, OffEvCtrl, 32'h0);
    fail_pulse();
    chk("ev disabled", evCount, 1);
  endtask : t_event

  // mid-run reset drops a pending request
  task automatic t_rst;
    wb(1'b1, OffEnSet, 32'h8);
    statusIn.pllLockFall <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("irq pre", irqOut, 1'b1);
    rst <= 1'b1;
    statusIn.pllLockFall <= 1'b0;
    @(posedge ref_clk);
    chk("irq rst", irqOut, 1'b0);
    rst <= 1'b0;
    @(posedge ref_clk);
    rdc("flags rst", OffFlag, 32'h0);
    rdc("en rst", OffEnSet, 32'h0);
  endtask : t_rst

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end

  initial begin
    rst      = 1'b1;
    wbReq    = '0;
    statusIn = '0;
    globalEn = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_edges();
    t_irq();
    t_event();
    t_rst();
    results();
  end
endmodule : ocirq_unit_tb_top
